// file: include/rif_pkg.sv
// shared constants and state types of the radio flag register block
package rif_pkg;
	localparam int ADDR_W = 8;
	localparam int QCNT_W = 7;
	localparam int QUEUE_DEPTH = 66;
	// register indexes; byte address is four times the index
	localparam logic [5:0] IDX_CONFIG = 6'h20;
	localparam logic [5:0] IDX_SUPPLY_LOW = 6'h3D;
	localparam logic [5:0] IDX_FLAGS1 = 6'h3E;
	localparam logic [5:0] IDX_FLAGS2 = 6'h3F;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG = {IDX_CONFIG, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_SUPPLY_LOW = {IDX_SUPPLY_LOW, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_FLAGS1 = {IDX_FLAGS1, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_FLAGS2 = {IDX_FLAGS2, 2'h0};
	// operating modes
	localparam logic [2:0] MODE_SLEEP = 3'h0;
	localparam logic [2:0] MODE_STANDBY = 3'h1;
	localparam logic [2:0] MODE_SYNTH = 3'h2;
	localparam logic [2:0] MODE_TX = 3'h3;
	localparam logic [2:0] MODE_RX = 3'h4;
	// primary flag bits
	localparam int F1_READY = 7;
	localparam int F1_RX_SETTLED = 6;
	localparam int F1_TX_SETTLED = 5;
	localparam int F1_LOCK = 4;
	localparam int F1_SIG_OVER = 3;
	localparam int F1_TIMEOUT = 2;
	localparam int F1_PREAMBLE = 1;
	localparam int F1_SYNC = 0;
	// secondary flag bits
	localparam int F2_FULL = 7;
	localparam int F2_EMPTY = 6;
	localparam int F2_LEVEL = 5;
	localparam int F2_OVERFLOW = 4;
	localparam int F2_SENT = 3;
	localparam int F2_PAYLOAD = 2;
	localparam int F2_CRC = 1;
	localparam int F2_LOW = 0;
	// config register fields and supply low enable bit
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_PKT = 3;
	localparam int CFG_CRC_EN = 4;
	localparam int CFG_KEEP = 5;
	localparam int CFG_LVL_LSB = 8;
	localparam int CFG_SSL_LSB = 16;
	localparam int LB_EN = 3;
	// reset values and bus response codes
	localparam logic [7:0] FLAGS1_RST = 8'h00;
	localparam logic [7:0] FLAGS2_RST = 8'h40;
	localparam logic [2:0] LB_TRIM_RST = 3'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic aw_ok;
		logic w_ok;
		logic [ADDR_W-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rpend;
		logic [ADDR_W-1:0] raddr;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} rif_axil_s;
endpackage

// file: include/rif_reg_if.sv
// register access carrier between bus slave and flag logic
`timescale 1ns/10ps
interface rif_reg_if;
	import rif_pkg::*;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_ok;
	modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		input wr_ok, rd_data, rd_ok);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		output wr_ok, rd_data, rd_ok);
endinterface

// file: design/rif_axil_slave.sv
// axi4-lite slave front end of the flag register block
`timescale 1ns/10ps
module rif_axil_slave import rif_pkg::*; (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	rif_reg_if.bus regs
);
	rif_axil_s s_r;
	rif_axil_s s_nxt;
	logic do_wr;

	always_comb begin
		s_nxt = s_r;
		do_wr = s_r.aw_ok && s_r.w_ok && !s_r.bvalid;
		if (s_r.awready && s_axi_awvalid_in) begin
			s_nxt.aw_ok = 1'b1;
			s_nxt.waddr = s_axi_awaddr_in;
		end
		if (s_r.wready && s_axi_wvalid_in) begin
			s_nxt.w_ok = 1'b1;
			s_nxt.wdata = s_axi_wdata_in;
			s_nxt.wstrb = s_axi_wstrb_in;
		end
		if (do_wr) begin
			s_nxt.aw_ok = 1'b0;
			s_nxt.w_ok = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = regs.wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_r.bvalid && s_axi_bready_in) begin
			s_nxt.bvalid = 1'b0;
		end
		s_nxt.awready = !s_nxt.aw_ok && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_ok && !s_nxt.bvalid;
		// read: address, one cycle lookup, data
		if (s_r.arready && s_axi_arvalid_in) begin
			s_nxt.raddr = s_axi_araddr_in;
			s_nxt.rpend = 1'b1;
			s_nxt.arready = 1'b0;
		end
		if (s_r.rpend) begin
			s_nxt.rpend = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = regs.rd_data;
			s_nxt.rresp = regs.rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_r.rvalid && s_axi_rready_in) begin
			s_nxt.rvalid = 1'b0;
			s_nxt.arready = 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			s_r <= '0;
			s_r.awready <= 1'b1;
			s_r.wready <= 1'b1;
			s_r.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign regs.wr_en = do_wr;
	assign regs.wr_addr = s_r.waddr;
	assign regs.wr_data = s_r.wdata;
	assign regs.wr_strb = s_r.wstrb;
	assign regs.rd_addr = s_r.raddr;
	assign s_axi_awready_out = s_r.awready;
	assign s_axi_wready_out = s_r.wready;
	assign s_axi_bresp_out = s_r.bresp;
	assign s_axi_bvalid_out = s_r.bvalid;
	assign s_axi_arready_out = s_r.arready;
	assign s_axi_rdata_out = s_r.rdata;
	assign s_axi_rresp_out = s_r.rresp;
	assign s_axi_rvalid_out = s_r.rvalid;
endmodule

// file: design/rif_status_flags.sv
// interrupt and status flag registers of the radio, top level
// Functional notes
// (R1) ready flag set when commanded mode reached
// (R2) ready flag cleared on any mode change
// (R3) receive settled set in rx, cleared leaving
// (R4) transmit settled after amp ramp, cleared leaving
// (R5) lock flag follows pll in synth/rx/tx
// (R6) strength over limit in rx; leave/w1c clears
// (R7) timeout set; cleared leaving rx or emptied
// (R8) preamble found set; cleared by writing one
// (R9) sync match set; leave rx/emptied clears
// (R10) sync match w1c only in continuous mode
// (R11) queue full exactly at 66 bytes
// (R12) queue empty when no bytes held
// (R13) level flag when count strictly above limit
// (R14) overflow set on overrun except in sleep
// (R15) writing one to overflow flushes queue, flags
// (R16) frame sent in tx, cleared leaving tx
// (R17) payload complete on last byte, checksum gated
// (R18) checksum good in rx, cleared when emptied
// (R19) supply low sticky until written one
// (R20) supply comparison only while monitor enabled
// (R21) zero writes and read-only bits ignored
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
module rif_status_flags import rif_pkg::*; #(
	parameter int QUEUE_DEPTH_P = QUEUE_DEPTH,
	parameter int QCNT_W_P = QCNT_W
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic xo_running_in,
	input wire logic pll_locked_in,
	input wire logic rx_sampling_in,
	input wire logic rx_settled_in,
	input wire logic pa_ramped_in,
	input wire logic [7:0] signal_strength_in,
	input wire logic timeout_in,
	input wire logic preamble_in,
	input wire logic sync_addr_in,
	input wire logic [QCNT_W_P-1:0] queue_count_in,
	input wire logic queue_overrun_in,
	input wire logic packet_sent_in,
	input wire logic payload_last_in,
	input wire logic checksum_ok_in,
	input wire logic battery_low_in,
	output logic [2:0] op_mode_out,
	output logic queue_clear_out,
	output logic supply_monitor_enable_out,
	output logic [2:0] supply_trim_out,
	output logic [7:0] flags_primary_out,
	output logic [7:0] flags_secondary_out
);
	if (QUEUE_DEPTH_P >= (1 << QCNT_W_P) || QCNT_W_P > 8) begin : g_chk
		$error("queue depth does not fit count width");
	end

	localparam logic [QCNT_W_P-1:0] DEPTH_C = QCNT_W_P'(QUEUE_DEPTH_P);
	localparam logic [QCNT_W_P-1:0] ZERO_C = '0;

	typedef struct packed {
		logic [2:0] mode;
		logic [2:0] cur;
		logic pkt;
		logic crc_en;
		logic keep;
		logic [QCNT_W_P-1:0] lvl;
		logic [7:0] ssl;
		logic [7:0] f1;
		logic [7:0] f2;
		logic lb_en;
		logic [2:0] lb_trim;
		logic qclr;
	} rif_state_s;

	rif_state_s s_r;
	rif_state_s s_nxt;
	rif_reg_if regs_if ();

	logic chg;
	logic in_rx;
	logic in_tx;
	logic leave_rx;
	logic leave_tx;
	logic rdy_cond;
	logic emptied;
	logic clr_q;
	logic wr_lane0;
	logic [7:0] w1c1;
	logic [7:0] w1c2;

	rif_axil_slave u_bus (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.s_axi_awaddr_in(s_axi_awaddr_in),
		.s_axi_awvalid_in(s_axi_awvalid_in),
		.s_axi_awready_out(s_axi_awready_out),
		.s_axi_wdata_in(s_axi_wdata_in),
		.s_axi_wstrb_in(s_axi_wstrb_in),
		.s_axi_wvalid_in(s_axi_wvalid_in),
		.s_axi_wready_out(s_axi_wready_out),
		.s_axi_bresp_out(s_axi_bresp_out),
		.s_axi_bvalid_out(s_axi_bvalid_out),
		.s_axi_bready_in(s_axi_bready_in),
		.s_axi_araddr_in(s_axi_araddr_in),
		.s_axi_arvalid_in(s_axi_arvalid_in),
		.s_axi_arready_out(s_axi_arready_out),
		.s_axi_rdata_out(s_axi_rdata_out),
		.s_axi_rresp_out(s_axi_rresp_out),
		.s_axi_rvalid_out(s_axi_rvalid_out),
		.s_axi_rready_in(s_axi_rready_in),
		.regs(regs_if.bus)
	);

	// mode tracking and write decode
	always_comb begin
		chg = s_r.mode != s_r.cur;
		in_rx = (s_r.cur == MODE_RX) && !chg;
		in_tx = (s_r.cur == MODE_TX) && !chg;
		leave_rx = chg && (s_r.cur == MODE_RX);
		leave_tx = chg && (s_r.cur == MODE_TX);
		wr_lane0 = regs_if.wr_en && regs_if.wr_strb[0];
		// only ones on lane 0 of a flag register act
		w1c1 = (wr_lane0 && regs_if.wr_addr == ADDR_FLAGS1) ? regs_if.wr_data[7:0] : 8'h00; // see (R21)
		w1c2 = (wr_lane0 && regs_if.wr_addr == ADDR_FLAGS2) ? regs_if.wr_data[7:0] : 8'h00; // see (R21)
		clr_q = w1c2[F2_OVERFLOW];
		emptied = (queue_count_in == ZERO_C && !s_r.f2[F2_EMPTY]) || clr_q;
		case (s_r.cur)
			MODE_SLEEP: rdy_cond = 1'b1; // see (R1)
			MODE_STANDBY: rdy_cond = xo_running_in; // see (R1)
			MODE_SYNTH: rdy_cond = pll_locked_in; // see (R1)
			MODE_RX: rdy_cond = rx_sampling_in; // see (R1)
			MODE_TX: rdy_cond = pa_ramped_in; // see (R1)
			default: rdy_cond = 1'b0;
		endcase
	end

	// read mux
	always_comb begin
		regs_if.rd_ok = 1'b1;
		case (regs_if.rd_addr)
			ADDR_FLAGS1: regs_if.rd_data = {24'h000000, s_r.f1};
			ADDR_FLAGS2: regs_if.rd_data = {24'h000000, s_r.f2};
			ADDR_SUPPLY_LOW: regs_if.rd_data = {28'h0000000, s_r.lb_en, s_r.lb_trim};
			ADDR_CONFIG: begin
				regs_if.rd_data = '0;
				regs_if.rd_data[CFG_MODE_LSB +: 3] = s_r.mode;
				regs_if.rd_data[CFG_PKT] = s_r.pkt;
				regs_if.rd_data[CFG_CRC_EN] = s_r.crc_en;
				regs_if.rd_data[CFG_KEEP] = s_r.keep;
				regs_if.rd_data[CFG_LVL_LSB +: QCNT_W_P] = s_r.lvl;
				regs_if.rd_data[CFG_SSL_LSB +: 8] = s_r.ssl;
			end
			default: begin
				regs_if.rd_data = '0;
				regs_if.rd_ok = 1'b0;
			end
		endcase
		case (regs_if.wr_addr)
			ADDR_FLAGS1, ADDR_FLAGS2, ADDR_SUPPLY_LOW, ADDR_CONFIG: regs_if.wr_ok = 1'b1;
			default: regs_if.wr_ok = 1'b0;
		endcase
	end

	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.cur = s_r.mode;
		if (regs_if.wr_en && regs_if.wr_addr == ADDR_CONFIG) begin
			if (regs_if.wr_strb[0]) begin
				s_nxt.mode = regs_if.wr_data[CFG_MODE_LSB +: 3];
				s_nxt.pkt = regs_if.wr_data[CFG_PKT];
				s_nxt.crc_en = regs_if.wr_data[CFG_CRC_EN];
				s_nxt.keep = regs_if.wr_data[CFG_KEEP];
			end
			if (regs_if.wr_strb[1]) begin
				s_nxt.lvl = regs_if.wr_data[CFG_LVL_LSB +: QCNT_W_P];
			end
			if (regs_if.wr_strb[2]) begin
				s_nxt.ssl = regs_if.wr_data[CFG_SSL_LSB +: 8];
			end
		end
		if (wr_lane0 && regs_if.wr_addr == ADDR_SUPPLY_LOW) begin
			s_nxt.lb_en = regs_if.wr_data[LB_EN];
			s_nxt.lb_trim = regs_if.wr_data[2:0];
		end
		// primary flags; a set in the clearing cycle wins, except ready, which a mode change clears
		s_nxt.f1[F1_READY] = !chg && (s_r.f1[F1_READY] || rdy_cond); // see (R1) (R2)
		s_nxt.f1[F1_RX_SETTLED] = (in_rx && rx_settled_in)
			|| (s_r.f1[F1_RX_SETTLED] && !leave_rx); // see (R3)
		s_nxt.f1[F1_TX_SETTLED] = (in_tx && pa_ramped_in)
			|| (s_r.f1[F1_TX_SETTLED] && !leave_tx); // see (R4)
		s_nxt.f1[F1_LOCK] = pll_locked_in && (s_r.cur == MODE_SYNTH
			|| s_r.cur == MODE_RX || s_r.cur == MODE_TX); // see (R5)
		s_nxt.f1[F1_SIG_OVER] = (in_rx && signal_strength_in > s_r.ssl)
			|| (s_r.f1[F1_SIG_OVER] && !leave_rx && !w1c1[F1_SIG_OVER]); // see (R6)
		s_nxt.f1[F1_TIMEOUT] = timeout_in
			|| (s_r.f1[F1_TIMEOUT] && !leave_rx && !emptied); // see (R7)
		s_nxt.f1[F1_PREAMBLE] = preamble_in
			|| (s_r.f1[F1_PREAMBLE] && !w1c1[F1_PREAMBLE]); // see (R8)
		s_nxt.f1[F1_SYNC] = sync_addr_in || (s_r.f1[F1_SYNC] && !leave_rx
			&& !emptied && !(w1c1[F1_SYNC] && !s_r.pkt)); // see (R9) (R10)
		// queue flags follow the count unless a flush is under way
		if (clr_q || s_r.qclr) begin
			s_nxt.f2[F2_FULL] = 1'b0; // see (R15)
			s_nxt.f2[F2_EMPTY] = 1'b1; // see (R15)
			s_nxt.f2[F2_LEVEL] = 1'b0; // see (R15)
		end else begin
			s_nxt.f2[F2_FULL] = queue_count_in == DEPTH_C; // see (R11)
			s_nxt.f2[F2_EMPTY] = queue_count_in == ZERO_C; // see (R12)
			s_nxt.f2[F2_LEVEL] = queue_count_in > s_r.lvl; // see (R13)
		end
		s_nxt.f2[F2_OVERFLOW] = (queue_overrun_in && s_r.cur != MODE_SLEEP)
			|| (s_r.f2[F2_OVERFLOW] && !clr_q); // see (R14)
		s_nxt.qclr = clr_q; // see (R15)
		s_nxt.f2[F2_SENT] = (in_tx && packet_sent_in)
			|| (s_r.f2[F2_SENT] && !leave_tx); // see (R16)
		s_nxt.f2[F2_PAYLOAD] = (in_rx && payload_last_in
			&& (!s_r.crc_en || s_r.keep || checksum_ok_in))
			|| (s_r.f2[F2_PAYLOAD] && !emptied); // see (R17)
		s_nxt.f2[F2_CRC] = (in_rx && payload_last_in && checksum_ok_in)
			|| (s_r.f2[F2_CRC] && !emptied); // see (R18)
		s_nxt.f2[F2_LOW] = (s_r.lb_en && battery_low_in) // see (R20)
			|| (s_r.f2[F2_LOW] && !w1c2[F2_LOW]); // see (R19)
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			s_r <= '0;
			s_r.f1 <= FLAGS1_RST;
			s_r.f2 <= FLAGS2_RST;
			s_r.lb_trim <= LB_TRIM_RST;
			s_r.mode <= MODE_SLEEP;
			s_r.cur <= MODE_SLEEP;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign op_mode_out = s_r.cur;
	assign queue_clear_out = s_r.qclr;
	assign supply_monitor_enable_out = s_r.lb_en;
	assign supply_trim_out = s_r.lb_trim;
	assign flags_primary_out = s_r.f1;
	assign flags_secondary_out = s_r.f2;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	property p_ready_set;
		(s_r.cur == MODE_SLEEP) && !chg |=> flags_primary_out[F1_READY];
	endproperty
	a_ready_set: assert property (p_ready_set) else $error("ready not set in sleep"); // see (R1)

	property p_ready_clr;
		chg |=> !flags_primary_out[F1_READY] && op_mode_out == $past(s_r.mode);
	endproperty
	a_ready_clr: assert property (p_ready_clr) else $error("ready kept over mode change"); // see (R2)

	property p_rx_leave;
		leave_rx |=> !flags_primary_out[F1_RX_SETTLED] && !flags_primary_out[F1_SIG_OVER];
	endproperty
	a_rx_leave: assert property (p_rx_leave) else $error("rx flags kept after rx"); // see (R3)

	property p_tx_set;
		in_tx && pa_ramped_in |=> flags_primary_out[F1_TX_SETTLED];
	endproperty
	a_tx_set: assert property (p_tx_set) else $error("transmit settled missing"); // see (R4)

	property p_lock;
		(s_r.cur == MODE_SYNTH || s_r.cur == MODE_RX || s_r.cur == MODE_TX)
			|=> flags_primary_out[F1_LOCK] == $past(pll_locked_in);
	endproperty
	a_lock: assert property (p_lock) else $error("lock flag wrong"); // see (R5)

	property p_preamble;
		preamble_in |=> flags_primary_out[F1_PREAMBLE];
	endproperty
	a_preamble: assert property (p_preamble) else $error("preamble flag missing"); // see (R8)

	property p_sync_ro;
		s_r.pkt && flags_primary_out[F1_SYNC] && !leave_rx && !emptied
			|=> flags_primary_out[F1_SYNC];
	endproperty
	a_sync_ro: assert property (p_sync_ro) else $error("sync flag cleared in packet mode"); // see (R10)

	property p_full;
		!clr_q && !s_r.qclr && queue_count_in == DEPTH_C
			|=> flags_secondary_out[F2_FULL] && !flags_secondary_out[F2_EMPTY];
	endproperty
	a_full: assert property (p_full) else $error("full flag wrong"); // see (R11)

	property p_overrun;
		queue_overrun_in && s_r.cur != MODE_SLEEP |=> flags_secondary_out[F2_OVERFLOW];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overflow not flagged"); // see (R14)

	sequence s_flush;
		queue_clear_out && flags_secondary_out[F2_EMPTY] && !flags_secondary_out[F2_OVERFLOW]
			##1 !queue_clear_out && flags_secondary_out[F2_EMPTY];
	endsequence
	property p_flush;
		clr_q && !queue_overrun_in |=> s_flush;
	endproperty
	a_flush: assert property (p_flush) else $error("flush sequence wrong"); // see (R15)

	property p_payload;
		in_rx && payload_last_in && s_r.crc_en && !s_r.keep && !checksum_ok_in
			&& !flags_secondary_out[F2_PAYLOAD] |=> !flags_secondary_out[F2_PAYLOAD];
	endproperty
	a_payload: assert property (p_payload) else $error("payload set on bad checksum"); // see (R17)

	property p_low_off;
		!supply_monitor_enable_out && !flags_secondary_out[F2_LOW]
			|=> !flags_secondary_out[F2_LOW];
	endproperty
	a_low_off: assert property (p_low_off) else $error("supply low set while disabled"); // see (R20)

	property p_low_hold;
		flags_secondary_out[F2_LOW] && !w1c2[F2_LOW] |=> flags_secondary_out[F2_LOW];
	endproperty
	a_low_hold: assert property (p_low_hold) else $error("supply low dropped"); // see (R19)
endmodule

// file: sim/rif_status_flags_bench.sv
// self-checking bench of the radio flag register block
`timescale 1ns/10ps
module rif_status_flags_bench;
	import rif_pkg::*;
	logic clock_in, rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
	logic s_axi_arvalid_in, s_axi_rready_in, xo_running_in, pll_locked_in;
	logic rx_sampling_in, rx_settled_in, pa_ramped_in, timeout_in, preamble_in;
	logic sync_addr_in, queue_overrun_in, packet_sent_in, payload_last_in;
	logic checksum_ok_in, battery_low_in;
	logic [ADDR_W-1:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, cfg, rd;
	logic [3:0] s_axi_wstrb_in;
	logic [7:0] signal_strength_in, flags_primary_out, flags_secondary_out;
	logic [QCNT_W-1:0] queue_count_in;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, queue_clear_out, supply_monitor_enable_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
	logic [2:0] op_mode_out, supply_trim_out;
	int n_mismatch, n_checks, n_clr, c0;
	rif_status_flags #(.QUEUE_DEPTH_P(QUEUE_DEPTH), .QCNT_W_P(QCNT_W)) u_rif_status_flags (
		.clock_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
		.s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
		.s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
		.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
		.s_axi_rvalid_out, .s_axi_rready_in, .xo_running_in, .pll_locked_in,
		.rx_sampling_in, .rx_settled_in, .pa_ramped_in, .signal_strength_in, .timeout_in,
		.preamble_in, .sync_addr_in, .queue_count_in, .queue_overrun_in, .packet_sent_in,
		.payload_last_in, .checksum_ok_in, .battery_low_in, .op_mode_out, .queue_clear_out,
		.supply_monitor_enable_out, .supply_trim_out, .flags_primary_out,
		.flags_secondary_out
	);
	initial begin
		clock_in = 1'h0;
		forever #10 clock_in = ~clock_in;
	end
	always @(posedge clock_in) if (queue_clear_out === 1'h1) n_clr <= n_clr + 1;
	task automatic test_done();
		if (n_mismatch == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic hang();
		check("bus answer", 32'h0, 32'h1);
		test_done();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clock_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'h1;
		s_axi_wvalid_in <= 1'h1;
		s_axi_bready_in <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge clock_in);
			if (s_axi_awready_out === 1'h1) s_axi_awvalid_in <= 1'h0;
			if (s_axi_wready_out === 1'h1) s_axi_wvalid_in <= 1'h0;
			if (s_axi_bvalid_out === 1'h1) break;
		end
		if (n == 40) hang();
		r = s_axi_bresp_out;
		s_axi_bready_in <= 1'h0;
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clock_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'h1;
		s_axi_rready_in <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge clock_in);
			if (s_axi_arready_out === 1'h1) s_axi_arvalid_in <= 1'h0;
			if (s_axi_rvalid_out === 1'h1) break;
		end
		if (n == 40) hang();
		d = s_axi_rdata_out;
		r = s_axi_rresp_out;
		s_axi_rready_in <= 1'h0;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, rsp);
		check("bresp", rsp, RESP_OKAY);
	endtask
	task automatic mode(input logic [2:0] m);
		cfg[2:0] = m;
		wreg(ADDR_CONFIG, cfg);
	endtask
	task automatic f1(input int b, input logic e);
		tick(3);
		check("flags1 bit", flags_primary_out[b], e);
	endtask
	task automatic f2(input int b, input logic e);
		tick(3);
		check("flags2 bit", flags_secondary_out[b], e);
	endtask
	task automatic ev(input logic t, input logic p, input logic s);
		timeout_in <= t;
		preamble_in <= p;
		sync_addr_in <= s;
		tick(1);
		{timeout_in, preamble_in, sync_addr_in} <= 3'h0;
		tick(1);
	endtask
	task automatic cnt(input logic [QCNT_W-1:0] v);
		queue_count_in <= v;
		tick(2);
	endtask
	task automatic last(input logic ok);
		payload_last_in <= 1'h1;
		checksum_ok_in <= ok;
		tick(1);
		payload_last_in <= 1'h0;
	endtask
	task automatic t_regs();
		rdr(8'h10, rd, rsp);
		check("unmapped rdata", rd, 32'h0);
		check("unmapped rresp", rsp, RESP_SLVERR);
		wr(8'h10, 32'hFF, rsp);
		check("unmapped bresp", rsp, RESP_SLVERR);
		rdr(ADDR_SUPPLY_LOW, rd, rsp);
		check("supply_low reset", rd, 32'h2);
	endtask
	task automatic t_mode();
		mode(MODE_STANDBY);
		f1(F1_READY, 1'h0);
		check("op mode", op_mode_out, MODE_STANDBY);
		xo_running_in <= 1'h1;
		f1(F1_READY, 1'h1);
		mode(MODE_SYNTH);
		f1(F1_READY, 1'h0);
		f1(F1_LOCK, 1'h0);
		pll_locked_in <= 1'h1;
		f1(F1_READY, 1'h1);
		f1(F1_LOCK, 1'h1);
		mode(MODE_RX);
		f1(F1_READY, 1'h0);
		rx_sampling_in <= 1'h1;
		rx_settled_in <= 1'h1;
		f1(F1_READY, 1'h1);
		f1(F1_RX_SETTLED, 1'h1);
		mode(MODE_TX);
		f1(F1_RX_SETTLED, 1'h0);
		f1(F1_TX_SETTLED, 1'h0);
		pa_ramped_in <= 1'h1;
		packet_sent_in <= 1'h1;
		f1(F1_TX_SETTLED, 1'h1);
		f2(F2_SENT, 1'h1);
		packet_sent_in <= 1'h0;
		pll_locked_in <= 1'h0;
		f1(F1_LOCK, 1'h0);
		mode(MODE_STANDBY);
		f1(F1_TX_SETTLED, 1'h0);
		f2(F2_SENT, 1'h0);
		{pa_ramped_in, rx_sampling_in, rx_settled_in} <= 3'h0;
	endtask
	task automatic t_rx();
		cfg[23:16] = 8'h40;
		mode(MODE_RX);
		cnt(7'h05);
		signal_strength_in <= 8'h40;
		f1(F1_SIG_OVER, 1'h0);
		signal_strength_in <= 8'h41;
		f1(F1_SIG_OVER, 1'h1);
		signal_strength_in <= 8'h00;
		wreg(ADDR_FLAGS1, 32'h0);
		f1(F1_SIG_OVER, 1'h1);
		wreg(ADDR_FLAGS1, 32'h8);
		f1(F1_SIG_OVER, 1'h0);
		ev(1'h1, 1'h1, 1'h1);
		f1(F1_PREAMBLE, 1'h1);
		wreg(ADDR_FLAGS1, 32'h7);
		f1(F1_PREAMBLE, 1'h0);
		f1(F1_SYNC, 1'h0);
		f1(F1_TIMEOUT, 1'h1);
		cnt(7'h00);
		f1(F1_TIMEOUT, 1'h0);
		cfg[CFG_PKT] = 1'h1;
		wreg(ADDR_CONFIG, cfg);
		cnt(7'h05);
		ev(1'h1, 1'h0, 1'h1);
		wreg(ADDR_FLAGS1, 32'h1);
		f1(F1_SYNC, 1'h1);
		cnt(7'h00);
		f1(F1_SYNC, 1'h0);
		f1(F1_TIMEOUT, 1'h0);
		ev(1'h1, 1'h0, 1'h1);
		signal_strength_in <= 8'h41;
		f1(F1_SIG_OVER, 1'h1);
		signal_strength_in <= 8'h00;
		mode(MODE_STANDBY);
		f1(F1_SYNC, 1'h0);
		f1(F1_TIMEOUT, 1'h0);
		f1(F1_SIG_OVER, 1'h0);
	endtask
	task automatic t_queue();
		cfg[14:8] = 7'h0A;
		mode(MODE_SLEEP);
		f1(F1_READY, 1'h1);
		queue_overrun_in <= 1'h1;
		f2(F2_OVERFLOW, 1'h0);
		queue_overrun_in <= 1'h0;
		cnt(7'h0A);
		f2(F2_LEVEL, 1'h0);
		f2(F2_EMPTY, 1'h0);
		cnt(7'h0B);
		f2(F2_LEVEL, 1'h1);
		f2(F2_FULL, 1'h0);
		cnt(7'h42);
		f2(F2_FULL, 1'h1);
		cnt(7'h41);
		f2(F2_FULL, 1'h0);
		mode(MODE_STANDBY);
		queue_overrun_in <= 1'h1;
		f2(F2_OVERFLOW, 1'h1);
		queue_overrun_in <= 1'h0;
		wreg(ADDR_FLAGS2, 32'h0);
		f2(F2_OVERFLOW, 1'h1);
		c0 = n_clr;
		wreg(ADDR_FLAGS2, 32'h10);
		f2(F2_OVERFLOW, 1'h0);
		check("flush pulses", n_clr - c0, 32'h1);
		cnt(7'h00);
		f2(F2_EMPTY, 1'h1);
	endtask
	task automatic t_pay();
		cfg[CFG_CRC_EN] = 1'h1;
		mode(MODE_RX);
		cnt(7'h03);
		last(1'h0);
		f2(F2_PAYLOAD, 1'h0);
		f2(F2_CRC, 1'h0);
		last(1'h1);
		f2(F2_PAYLOAD, 1'h1);
		f2(F2_CRC, 1'h1);
		cnt(7'h00);
		f2(F2_PAYLOAD, 1'h0);
		f2(F2_CRC, 1'h0);
		cfg[CFG_KEEP] = 1'h1;
		wreg(ADDR_CONFIG, cfg);
		cnt(7'h03);
		last(1'h0);
		f2(F2_PAYLOAD, 1'h1);
		cnt(7'h00);
		cfg[CFG_KEEP] = 1'h0;
		cfg[CFG_CRC_EN] = 1'h0;
		wreg(ADDR_CONFIG, cfg);
		cnt(7'h03);
		last(1'h0);
		f2(F2_PAYLOAD, 1'h1);
		cnt(7'h00);
	endtask
	task automatic t_sup();
		battery_low_in <= 1'h1;
		f2(F2_LOW, 1'h0);
		wreg(ADDR_SUPPLY_LOW, 32'hA);
		check("monitor enable", supply_monitor_enable_out, 1'h1);
		check("trim", supply_trim_out, 3'h2);
		f2(F2_LOW, 1'h1);
		battery_low_in <= 1'h0;
		f2(F2_LOW, 1'h1);
		wreg(ADDR_FLAGS2, 32'h0);
		f2(F2_LOW, 1'h1);
		wreg(ADDR_FLAGS2, 32'h1);
		f2(F2_LOW, 1'h0);
		rdr(ADDR_FLAGS2, rd, rsp);
		check("flags2 read", rd, 32'h40);
		rdr(ADDR_SUPPLY_LOW, rd, rsp);
		check("supply_low read", rd, 32'hA);
	endtask
	initial begin
		n_mismatch = 0;
		n_checks = 0;
		n_clr = 0;
		cfg = 32'h0;
		rst_in = 1'h1;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = 4'h0;
		{s_axi_rready_in, xo_running_in, pll_locked_in, rx_sampling_in} = 4'h0;
		{rx_settled_in, pa_ramped_in, timeout_in, preamble_in, sync_addr_in} = 5'h0;
		{queue_overrun_in, packet_sent_in, payload_last_in} = 3'h0;
		{checksum_ok_in, battery_low_in} = 2'h0;
		s_axi_awaddr_in = 8'h0;
		s_axi_araddr_in = 8'h0;
		s_axi_wdata_in = 32'h0;
		s_axi_wstrb_in = 4'hF;
		signal_strength_in = 8'h0;
		queue_count_in = 7'h0;
		tick(20);
		check("flags1 reset", flags_primary_out, FLAGS1_RST);
		check("flags2 reset", flags_secondary_out, FLAGS2_RST);
		check("mode reset", op_mode_out, MODE_SLEEP);
		check("trim reset", supply_trim_out, LB_TRIM_RST);
		rst_in <= 1'h0;
		t_regs();
		t_mode();
		t_rx();
		t_queue();
		t_pay();
		t_sup();
		test_done();
	end
endmodule
